// ---- bench/aasl_decoder_model.sv ----
// Behavioural instruction decoder feeding the datapath slice.
`timescale 1ns/1ps
module aasl_decoder_model (
    // Clock
    input wire logic mclk,
    // Instruction to the slice
    output logic instr_valid,
    output aasl_pkg::aasl_instr_t instr
);
    initial begin
        instr_valid = 1'b0;
        instr = '0;
    end

    // ==========================================================
    // Issue
    // Idle fields are inverted so that nothing leans on stale operands.
    task automatic issue(input aasl_pkg::aasl_op_t op, input logic [6:0] fa, input logic d,
        input logic ps, input logic [7:0] lit);
        @(posedge mclk);
        instr_valid <= 1'b1;
        instr <= '{op: op, file_addr: fa, dest: d, ptr_sel: ps, literal: lit};
        @(posedge mclk);
        instr_valid <= 1'b0;
        instr <= aasl_pkg::aasl_instr_t'(~{op, fa, d, ps, lit});
    endtask
endmodule

// ---- bench/aasl_monitor.sv ----
// Concurrent checks on the ports of the datapath slice.
`timescale 1ns/1ps
module aasl_monitor #(
    parameter int FILE_DEPTH = 128
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Instruction in, result out
    input wire logic instr_valid,
    input wire aasl_pkg::aasl_instr_t instr,
    input wire logic result_valid,
    input wire logic [aasl_pkg::DATA_W-1:0] result_data,
    input wire logic [aasl_pkg::DATA_W-1:0] acc_value,
    input wire logic carry_flag,
    input wire logic nibble_overflow_bit,
    input wire logic zero_flag
);
    // ==========================================================
    // Decode helpers
    aasl_pkg::aasl_op_t op;
    logic fop;
    assign op = instr.op;
    assign fop = instr_valid && op inside {aasl_pkg::and_acc_with_file_op,
        aasl_pkg::add_acc_to_file_op, aasl_pkg::add_with_carry_op, aasl_pkg::arith_shift_right_op};
    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    // ==========================================================
    // Properties
    property p_pulse;
        1'b1 |=> result_valid == $past(instr_valid);
    endproperty
    a_pulse: assert property (p_pulse) else $error("result pulse wrong");
    property p_ptr_keep;
        instr_valid && op == aasl_pkg::pointer_add_literal_op
            |=> $stable({carry_flag, nibble_overflow_bit, zero_flag, acc_value});
    endproperty
    a_ptr_keep: assert property (p_ptr_keep) else $error("pointer add moved state");
    property p_and_lit;
        instr_valid && op == aasl_pkg::and_literal_to_acc_op |=> acc_value ==
            ($past(acc_value) & $past(instr.literal)) && zero_flag == (acc_value == 8'h00)
            && $stable({carry_flag, nibble_overflow_bit});
    endproperty
    a_and_lit: assert property (p_and_lit) else $error("and literal wrong");
    property p_add_lit;
        instr_valid && op == aasl_pkg::add_literal_to_acc_op |=> {carry_flag, acc_value} ==
            {1'b0, $past(acc_value)} + {1'b0, $past(instr.literal)} && nibble_overflow_bit ==
            ({1'b0, $past(acc_value[3:0])} + {1'b0, $past(instr.literal[3:0])} > 5'h0f)
            && zero_flag == (acc_value == 8'h00);
    endproperty
    a_add_lit: assert property (p_add_lit) else $error("add literal wrong");
    property p_dest_file;
        fop && instr.dest |=> $stable(acc_value);
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("acc written");
    property p_dest_acc;
        fop && !instr.dest |=> acc_value == result_data;
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("acc not written");
    property p_and_file;
        instr_valid && op == aasl_pkg::and_acc_with_file_op |=> zero_flag ==
            (result_data == 8'h00) && $stable({carry_flag, nibble_overflow_bit});
    endproperty
    a_and_file: assert property (p_and_file) else $error("and file flags wrong");
    property p_add_zero;
        instr_valid && op inside {aasl_pkg::add_acc_to_file_op, aasl_pkg::add_with_carry_op}
            |=> zero_flag == (result_data == 8'h00);
    endproperty
    a_add_zero: assert property (p_add_zero) else $error("add zero wrong");
    property p_shift;
        instr_valid && op == aasl_pkg::arith_shift_right_op |=> result_data[7] == result_data[6]
            && zero_flag == (result_data == 8'h00) && $stable(nibble_overflow_bit);
    endproperty
    a_shift: assert property (p_shift) else $error("shift wrong");
    c_ptr: cover property (instr_valid && op == aasl_pkg::pointer_add_literal_op);
    c_carry: cover property (instr_valid && op == aasl_pkg::add_with_carry_op && carry_flag);
    c_top: cover property (fop && instr.file_addr == 7'(FILE_DEPTH - 1));
endmodule

bind aasl_alu_slice aasl_monitor #(.FILE_DEPTH(FILE_DEPTH)) u_mon (.mclk(mclk), .reset(reset),
    .instr_valid(instr_valid), .instr(instr), .result_valid(result_valid),
    .result_data(result_data), .acc_value(acc_value), .carry_flag(carry_flag),
    .nibble_overflow_bit(nibble_overflow_bit), .zero_flag(zero_flag));

// ---- bench/add_and_shift_alu_slice_test.sv ----
// Self-checking bench for the add-and-shift datapath slice.
`timescale 1ns/1ps
module add_and_shift_alu_slice_test;
    // ==========================================================
    // Signals
    localparam logic [11:0] AC = aasl_pkg::OFS_ACC;
    localparam logic [11:0] ST = aasl_pkg::OFS_STATUS;
    logic mclk = 1'b0;
    logic reset = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic instr_valid, result_valid, carry_flag, nibble_overflow_bit, zero_flag, pready, pslverr;
    aasl_pkg::aasl_instr_t instr;
    logic [7:0] result_data, acc_value;
    logic [31:0] prdata, tmp;
    logic last_err;
    int fails = 0;
    int n_compared = 0;
    always #2 mclk = ~mclk;

    aasl_alu_slice #(.FILE_DEPTH(128)) u_dut (.mclk(mclk), .reset(reset),
        .instr_valid(instr_valid), .instr(instr), .result_valid(result_valid),
        .result_data(result_data), .acc_value(acc_value), .carry_flag(carry_flag),
        .nibble_overflow_bit(nibble_overflow_bit), .zero_flag(zero_flag), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    aasl_decoder_model u_dec (.mclk(mclk), .instr_valid(instr_valid), .instr(instr));

    // ==========================================================
    // Shared tasks
    task automatic results();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // Read data and the error flag are taken at the edge where pready is seen high.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
        output logic [31:0] rd);
        int k;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) begin
            fails++;
            results();
        end
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, tmp);
    endtask

    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, tmp);
        chk(tmp, e);
    endtask

    function automatic logic [11:0] fa(input int i);
        return aasl_pkg::OFS_FILE_BASE + 12'(4 * i);
    endfunction

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rdc(AC, 32'h0);
        rdc(ST, 32'h0);
        rdc(aasl_pkg::OFS_PTR1, 32'h0);
        rdc(12'h100, 32'h0);
        chk(32'(last_err), 32'h1);
    endtask

    task automatic t_ptr();
        wr(ST, 32'h7);
        wr(aasl_pkg::OFS_PTR0, 32'hffff);
        u_dec.issue(aasl_pkg::pointer_add_literal_op, 7'h00, 1'b0, 1'b0, 8'h01);
        u_dec.issue(aasl_pkg::pointer_add_literal_op, 7'h00, 1'b0, 1'b1, 8'he0);
        rdc(aasl_pkg::OFS_PTR0, 32'h0);
        rdc(aasl_pkg::OFS_PTR1, 32'hffe0);
        rdc(ST, 32'h7);
    endtask

    task automatic t_lit();
        wr(AC, 32'h3c);
        u_dec.issue(aasl_pkg::and_literal_to_acc_op, 7'h00, 1'b1, 1'b0, 8'h0f);
        rdc(AC, 32'h0c);
        rdc(ST, 32'h3);
        u_dec.issue(aasl_pkg::add_literal_to_acc_op, 7'h00, 1'b0, 1'b0, 8'h03);
        rdc(ST, 32'h0);
        u_dec.issue(aasl_pkg::add_literal_to_acc_op, 7'h00, 1'b0, 1'b0, 8'hf1);
        rdc(AC, 32'h0);
        rdc(ST, 32'h7);
    endtask

    task automatic t_file();
        wr(AC, 32'hc5);
        wr(fa(127), 32'h3c);
        wr(ST, 32'h0);
        u_dec.issue(aasl_pkg::add_acc_to_file_op, 7'd127, 1'b1, 1'b0, 8'h00);
        rdc(fa(127), 32'h01);
        rdc(AC, 32'hc5);
        rdc(ST, 32'h3);
        u_dec.issue(aasl_pkg::and_acc_with_file_op, 7'd127, 1'b0, 1'b0, 8'h00);
        rdc(AC, 32'h01);
        rdc(ST, 32'h3);
        u_dec.issue(aasl_pkg::add_with_carry_op, 7'd127, 1'b0, 1'b0, 8'h00);
        rdc(AC, 32'h03);
        rdc(ST, 32'h0);
        wr(fa(0), 32'hfd);
        u_dec.issue(aasl_pkg::add_with_carry_op, 7'd0, 1'b1, 1'b0, 8'h00);
        rdc(fa(0), 32'h0);
        rdc(ST, 32'h7);
    endtask

    task automatic t_shift();
        wr(fa(5), 32'h81);
        wr(fa(6), 32'h01);
        wr(ST, 32'h0);
        u_dec.issue(aasl_pkg::arith_shift_right_op, 7'd5, 1'b0, 1'b0, 8'h00);
        rdc(AC, 32'hc0);
        rdc(ST, 32'h1);
        u_dec.issue(aasl_pkg::arith_shift_right_op, 7'd6, 1'b1, 1'b0, 8'h00);
        rdc(fa(6), 32'h0);
        rdc(ST, 32'h5);
        chk(32'(result_data), 32'h00);
        u_dec.issue(aasl_pkg::no_op, 7'd6, 1'b1, 1'b0, 8'hff);
        rdc(fa(6), 32'h0);
        rdc(ST, 32'h5);
        chk(32'(result_data), 32'h00);
        chk(32'(acc_value), 32'hc0);
    endtask

    initial begin
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        t_reset();
        t_ptr();
        t_lit();
        t_file();
        t_shift();
        results();
    end
endmodule

// ---- logic/aasl_alu_slice.sv ----
// Add, AND and shift datapath slice with accumulator, flags, pointers and file registers.
//
// Notes on behaviour
// - Pointer add sign-extends a 6-bit literal onto the selected pointer; flags untouched.
// - Pointer sums wrap modulo 65536, never saturate.
// - AND literal puts acc AND literal in acc, updates zero only.
// - Add literal puts acc plus literal in acc, updates carry, nibble, zero.
// - File operations use a 7-bit address; dest 0 is acc, 1 the file.
// - AND with file sends acc AND file to destination, updates zero only.
// - Add with file sends acc plus file to destination, updates carry, nibble, zero.
// - Add with carry adds acc, file and carry; updates carry, nibble, zero.
// - Shift moves file bits 7:1 to result 6:0 and bit 0 into carry.
// - Shift keeps bit 7 as sign and updates zero with carry.
// - Pointer add completes in one instruction cycle.
//
// Our own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps

module aasl_alu_slice #(
    parameter int FILE_DEPTH = 128
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset,
    // Instruction from the decoder
    input wire logic instr_valid,
    input wire aasl_pkg::aasl_instr_t instr,
    // Instruction result
    output logic result_valid,
    output logic [aasl_pkg::DATA_W-1:0] result_data,
    output logic [aasl_pkg::DATA_W-1:0] acc_value,
    output logic carry_flag,
    output logic nibble_overflow_bit,
    output logic zero_flag,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [aasl_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);

    // ==========================================================
    // Elaboration checks
    // A depth beyond the file address range could never be reached by an instruction.
    if (FILE_DEPTH < 1 || FILE_DEPTH > (1 << aasl_pkg::FADDR_W)) begin : g_bad_depth
        $error("FILE_DEPTH must lie between 1 and the file address range.");
    end

    // ==========================================================
    // Local constants
    localparam logic [aasl_pkg::DATA_W-1:0] RST_ZERO = 8'h00;

    // ==========================================================
    // Helper functions
    // Zero test shared by every operation that updates the zero flag.
    function automatic logic is_zero(input logic [aasl_pkg::DATA_W-1:0] v);
        return v == RST_ZERO;
    endfunction

    // Only the low literal bits carry the signed offset; the rest are ignored.
    function automatic logic [aasl_pkg::PTR_W-1:0] sext_ptr_lit(
        input logic [aasl_pkg::DATA_W-1:0] lit);
        return {{(aasl_pkg::PTR_W-aasl_pkg::PTR_LIT_W){lit[aasl_pkg::PTR_LIT_W-1]}},
            lit[aasl_pkg::PTR_LIT_W-1:0]};
    endfunction

    function automatic aasl_pkg::aasl_sum_t add8(input logic [aasl_pkg::DATA_W-1:0] a,
                                                input logic [aasl_pkg::DATA_W-1:0] b,
                                                input logic cin);
        aasl_pkg::aasl_sum_t s;
        logic [aasl_pkg::NIBBLE_MSB+1:0] low;
        logic [aasl_pkg::DATA_W:0] full;
        low = {1'b0, a[aasl_pkg::NIBBLE_MSB:0]} + {1'b0, b[aasl_pkg::NIBBLE_MSB:0]}
            + {{aasl_pkg::NIBBLE_MSB+1{1'b0}}, cin};
        full = {1'b0, a} + {1'b0, b} + {{aasl_pkg::DATA_W{1'b0}}, cin};
        s.sum = full[aasl_pkg::DATA_W-1:0];
        s.carry = full[aasl_pkg::DATA_W];
        s.nibble = low[aasl_pkg::NIBBLE_MSB+1];
        return s;
    endfunction

    function automatic logic is_file(input logic [aasl_pkg::ADDR_W-1:0] a);
        return (a >= aasl_pkg::OFS_FILE_BASE)
            && ({20'h00000, a} < {20'h00000, aasl_pkg::OFS_FILE_BASE} + 32'(4 * FILE_DEPTH))
            && (a[1:0] == 2'b00);
    endfunction

    function automatic logic [aasl_pkg::FADDR_W-1:0] file_index(
        input logic [aasl_pkg::ADDR_W-1:0] a);
        logic [aasl_pkg::ADDR_W-1:0] d;
        d = a - aasl_pkg::OFS_FILE_BASE;
        return d[aasl_pkg::FADDR_W+1:2];
    endfunction

    // ==========================================================
    // State
    logic [aasl_pkg::DATA_W-1:0] acc_reg, acc_next;
    logic carry_reg, carry_next;
    logic nibble_reg, nibble_next;
    logic zero_reg, zero_next;
    logic [aasl_pkg::PTR_W-1:0] ptr_reg [2];
    logic [aasl_pkg::PTR_W-1:0] ptr_next [2];
    logic [aasl_pkg::DATA_W-1:0] file_mem [FILE_DEPTH];
    logic file_we;
    logic [aasl_pkg::FADDR_W-1:0] file_waddr;
    logic [aasl_pkg::DATA_W-1:0] file_wdata;
    logic [aasl_pkg::DATA_W-1:0] result_reg, result_next;
    logic valid_reg, valid_next;
    logic [31:0] prdata_reg, prdata_next;
    logic apb_setup, apb_write, apb_mapped;

    assign apb_setup = psel && !penable;
    assign apb_write = psel && penable && pwrite && apb_mapped;
    assign apb_mapped = (paddr == aasl_pkg::OFS_ACC) || (paddr == aasl_pkg::OFS_STATUS)
        || (paddr == aasl_pkg::OFS_PTR0) || (paddr == aasl_pkg::OFS_PTR1) || is_file(paddr);

    // ==========================================================
    // Next-state logic
    always_comb begin
        logic [aasl_pkg::DATA_W-1:0] fval;
        logic [aasl_pkg::DATA_W-1:0] res;
        logic has_res;
        logic to_file;
        aasl_pkg::aasl_sum_t s;
        fval = RST_ZERO;
        res = RST_ZERO;
        has_res = 1'b0;
        to_file = 1'b0;
        s = '0;
        acc_next = acc_reg;
        carry_next = carry_reg;
        nibble_next = nibble_reg;
        zero_next = zero_reg;
        ptr_next = ptr_reg;
        file_we = 1'b0;
        file_waddr = '0;
        file_wdata = '0;
        result_next = result_reg;
        valid_next = 1'b0;
        // Software writes go first so that a same-cycle instruction result overrides them.
        if (apb_write) begin
            if (paddr == aasl_pkg::OFS_ACC) begin
                acc_next = pwdata[aasl_pkg::DATA_W-1:0];
            end else if (paddr == aasl_pkg::OFS_STATUS) begin
                carry_next = pwdata[aasl_pkg::STAT_CARRY];
                nibble_next = pwdata[aasl_pkg::STAT_NIBBLE];
                zero_next = pwdata[aasl_pkg::STAT_ZERO];
            end else if (paddr == aasl_pkg::OFS_PTR0) begin
                ptr_next[0] = pwdata[aasl_pkg::PTR_W-1:0];
            end else if (paddr == aasl_pkg::OFS_PTR1) begin
                ptr_next[1] = pwdata[aasl_pkg::PTR_W-1:0];
            end else begin
                file_we = 1'b1;
                file_waddr = file_index(paddr);
                file_wdata = pwdata[aasl_pkg::DATA_W-1:0];
            end
        end
        if (instr_valid) begin
            // Addresses beyond the implemented depth read as zero.
            if (32'(instr.file_addr) < 32'(FILE_DEPTH)) begin
                fval = file_mem[instr.file_addr];
            end
            to_file = (instr.dest == aasl_pkg::DEST_FILE);
            case (instr.op)
                aasl_pkg::pointer_add_literal_op: begin
                    // Plain 16-bit addition drops the carry out, giving the wrap. Flags untouched.
                    ptr_next[instr.ptr_sel] = ptr_reg[instr.ptr_sel]
                        + sext_ptr_lit(instr.literal);
                end
                aasl_pkg::and_literal_to_acc_op: begin
                    res = acc_reg & instr.literal;
                    has_res = 1'b1;
                    to_file = 1'b0;
                    zero_next = is_zero(res);
                end
                aasl_pkg::add_literal_to_acc_op: begin
                    s = add8(acc_reg, instr.literal, 1'b0);
                    res = s.sum;
                    has_res = 1'b1;
                    to_file = 1'b0;
                    carry_next = s.carry;
                    nibble_next = s.nibble;
                    zero_next = is_zero(res);
                end
                aasl_pkg::and_acc_with_file_op: begin
                    res = acc_reg & fval;
                    has_res = 1'b1;
                    zero_next = is_zero(res);
                end
                aasl_pkg::add_acc_to_file_op: begin
                    s = add8(acc_reg, fval, 1'b0);
                    res = s.sum;
                    has_res = 1'b1;
                    carry_next = s.carry;
                    nibble_next = s.nibble;
                    zero_next = is_zero(res);
                end
                aasl_pkg::add_with_carry_op: begin
                    s = add8(acc_reg, fval, carry_reg);
                    res = s.sum;
                    has_res = 1'b1;
                    carry_next = s.carry;
                    nibble_next = s.nibble;
                    zero_next = is_zero(res);
                end
                aasl_pkg::arith_shift_right_op: begin
                    res = {fval[aasl_pkg::DATA_W-1], fval[aasl_pkg::DATA_W-1:1]};
                    has_res = 1'b1;
                    carry_next = fval[0];
                    zero_next = is_zero(res);
                end
                default: begin
                    has_res = 1'b0;
                end
            endcase
            valid_next = 1'b1;
            if (has_res) begin
                result_next = res;
                if (to_file) begin
                    file_we = 1'b1;
                    file_waddr = instr.file_addr;
                    file_wdata = res;
                end else begin
                    acc_next = res;
                end
            end
        end
        // Read data is captured in the setup cycle so that prdata comes from a flip-flop.
        prdata_next = prdata_reg;
        if (apb_setup) begin
            prdata_next = 32'h00000000;
            if (paddr == aasl_pkg::OFS_ACC) begin
                prdata_next[aasl_pkg::DATA_W-1:0] = acc_reg;
            end else if (paddr == aasl_pkg::OFS_STATUS) begin
                prdata_next[aasl_pkg::STAT_CARRY] = carry_reg;
                prdata_next[aasl_pkg::STAT_NIBBLE] = nibble_reg;
                prdata_next[aasl_pkg::STAT_ZERO] = zero_reg;
            end else if (paddr == aasl_pkg::OFS_PTR0) begin
                prdata_next[aasl_pkg::PTR_W-1:0] = ptr_reg[0];
            end else if (paddr == aasl_pkg::OFS_PTR1) begin
                prdata_next[aasl_pkg::PTR_W-1:0] = ptr_reg[1];
            end else if (is_file(paddr)) begin
                prdata_next[aasl_pkg::DATA_W-1:0] = file_mem[file_index(paddr)];
            end else begin
                prdata_next = 32'h00000000;
            end
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            acc_reg <= aasl_pkg::RST_ACC;
            carry_reg <= aasl_pkg::RST_FLAG;
            nibble_reg <= aasl_pkg::RST_FLAG;
            zero_reg <= aasl_pkg::RST_FLAG;
            ptr_reg[0] <= aasl_pkg::RST_PTR;
            ptr_reg[1] <= aasl_pkg::RST_PTR;
            result_reg <= aasl_pkg::RST_ACC;
            valid_reg <= 1'b0;
            prdata_reg <= 32'h00000000;
        end else begin
            acc_reg <= acc_next;
            carry_reg <= carry_next;
            nibble_reg <= nibble_next;
            zero_reg <= zero_next;
            ptr_reg <= ptr_next;
            result_reg <= result_next;
            valid_reg <= valid_next;
            prdata_reg <= prdata_next;
        end
    end

    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            // Clearing the whole array keeps instruction reads free of unknowns.
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_mem[i] <= aasl_pkg::RST_FILE;
            end
        end else if (file_we && (32'(file_waddr) < 32'(FILE_DEPTH))) begin
            file_mem[file_waddr] <= file_wdata;
        end
    end

    // ==========================================================
    // Outputs
    assign result_valid = valid_reg;
    assign result_data = result_reg;
    assign acc_value = acc_reg;
    assign carry_flag = carry_reg;
    assign nibble_overflow_bit = nibble_reg;
    assign zero_flag = zero_reg;
    assign prdata = prdata_reg;
    // Every register answers at once, so the access phase never stretches.
    assign pready = 1'b1;
    // Unmapped or unaligned addresses answer with an error, are ignored and read as zero.
    assign pslverr = psel && penable && !apb_mapped;

endmodule

// ---- logic/aasl_pkg.sv ----
// Shared types and constants of the add-and-shift datapath slice.
package aasl_pkg;

    // ==========================================================
    // Operand widths
    localparam int DATA_W = 8;
    localparam int PTR_W = 16;
    localparam int FADDR_W = 7;
    localparam int PTR_LIT_W = 6;
    localparam int NIBBLE_MSB = 3;

    // ==========================================================
    // Destination select and status bit positions
    localparam logic DEST_ACC = 1'b0;
    localparam logic DEST_FILE = 1'b1;
    localparam int STAT_CARRY = 0;
    localparam int STAT_NIBBLE = 1;
    localparam int STAT_ZERO = 2;

    // ==========================================================
    // Register map, byte addresses
    localparam int ADDR_W = 12;
    localparam logic [ADDR_W-1:0] OFS_ACC = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_PTR0 = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_PTR1 = 12'h00c;
    localparam logic [ADDR_W-1:0] OFS_FILE_BASE = 12'h200;

    // ==========================================================
    // Reset values
    localparam logic [DATA_W-1:0] RST_ACC = 8'h00;
    localparam logic [DATA_W-1:0] RST_FILE = 8'h00;
    localparam logic [PTR_W-1:0] RST_PTR = 16'h0000;
    localparam logic RST_FLAG = 1'b0;

    // ==========================================================
    // Operations and instruction carrier
    typedef enum logic [2:0] {
        no_op,
        pointer_add_literal_op,
        and_literal_to_acc_op,
        add_literal_to_acc_op,
        and_acc_with_file_op,
        add_acc_to_file_op,
        add_with_carry_op,
        arith_shift_right_op
    } aasl_op_t;

    typedef struct packed {
        aasl_op_t op;
        logic [FADDR_W-1:0] file_addr;
        logic dest;
        logic ptr_sel;
        logic [DATA_W-1:0] literal;
    } aasl_instr_t;

    typedef struct packed {
        logic [DATA_W-1:0] sum;
        logic carry;
        logic nibble;
    } aasl_sum_t;

endpackage
